// file: bench/bpm_plant.sv
// plant model: load-side voltage behind the main contactor
`timescale 1ns/10ps
`default_nettype none
module bpm_plant #(
  parameter logic [15:0] STEP = 16'h000A
) (
  input wire logic clock_i,
  input wire logic close_i,
  input wire logic stall_i,
  input wire logic [15:0] batt_i,
  output logic [15:0] load_o
);
  // ==========================================================
  // load capacitance charges while closed, drops to 0 at once when open
  always_ff @(posedge clock_i) begin
    if (!close_i) begin
      load_o <= 16'h0000;
    end else if (!stall_i && load_o < batt_i) begin
      load_o <= load_o + STEP; // stall models a slow load
    end
  end
endmodule : bpm_plant
`default_nettype wire

// file: bench/bpm_top_tb.sv
// self-checking bench for the battery protection monitor
`timescale 1ns/10ps
`default_nettype none
module bpm_top_tb;
  // ==========================================================
  // stimulus and observed signals
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [15:0] cmax = 16'h0E74;
  logic [15:0] cmin = 16'h0E10;
  logic [15:0] ichg = 16'h0000;
  logic [15:0] idis = 16'h0000;
  logic [15:0] tmax = 16'h0019;
  logic [15:0] tmin = 16'h0019;
  logic [15:0] tint = 16'h0019;
  logic [7:0] cells = 8'h10;
  logic [15:0] batt = 16'h03E8;
  logic chg_rdy = 1'b0;
  logic prst = 1'b0;
  logic stall = 1'b0;
  logic [31:0] rdata, d, obs;
  logic [15:0] load_v;
  logic chg_ct, load_ct, chg_en, main_ct, pre;
  logic [7:0] flags;
  int num_errors = 0;
  int check_count = 0;
  // trip and safe measurement per channel
  logic [15:0] trip [8] = '{16'h10CC, 16'h0B54, 16'h0258, 16'h0258,
    16'h0046, 16'hFFEC, 16'h005A, 16'h000F};
  logic [15:0] safe [8] = '{16'h0E74, 16'h0E10, 16'h0000, 16'h0000,
    16'h0019, 16'h0019, 16'h0019, 16'h0010};
  assign obs = {19'h0_0000, pre, main_ct, chg_en, load_ct, chg_ct, flags};

  // ==========================================================
  // design and plant
  bpm_top #(.MS_CYCLES(10)) i_dut (.clock_i(clock_i), .reset_i(reset_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata), .cell_max_mv_i(cmax), .cell_min_mv_i(cmin),
    .chg_current_i(ichg), .dis_current_i(idis), .ext_temp_max_i(tmax),
    .ext_temp_min_i(tmin), .int_temp_i(tint), .cells_present_i(cells),
    .batt_volt_i(batt), .load_volt_i(load_v), .charger_ready_i(chg_rdy),
    .prot_reset_i(prst), .chg_contactor_o(chg_ct),
    .load_contactor_o(load_ct), .charger_enable_o(chg_en),
    .main_contactor_o(main_ct), .precharge_o(pre), .prot_active_o(flags));
  bpm_plant i_plant (.clock_i(clock_i), .close_i(pre | main_ct),
    .stall_i(stall), .batt_i(batt), .load_o(load_v));

  // ==========================================================
  // shared tasks
  task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task close_out;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  task cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : cyc
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 d = rdata;
  endtask : rd
  // bounded wait for one observed output bit
  task wb(input int b, input logic v, input int n);
    int k;
    k = 0;
    #1;
    while (obs[b] !== v && k < n) begin
      cyc(1);
      k++;
    end
    chk("output bit", {31'h0, obs[b]}, {31'h0, v});
    if (obs[b] !== v) close_out;
  endtask : wb
  task setm(input int n, input logic on);
    logic [15:0] v;
    v = on ? trip[n] : safe[n];
    @(posedge clock_i);
    case (n)
      0: cmax <= v;
      1: cmin <= v;
      2: ichg <= v;
      3: idis <= v;
      4: tmax <= v;
      5: tmin <= v;
      6: tint <= v;
      default: cells <= v[7:0];
    endcase
  endtask : setm

  // ==========================================================
  // scenarios
  task t_each;
    for (int n = 0; n < 8; n++) begin
      wr({1'b1, 3'(n), 4'h8}, 32'h0000_0000);
      wr({1'b1, 3'(n), 4'hC}, 32'h0000_0000);
    end
    for (int n = 0; n < 8; n++) begin
      setm(n, 1'b1);
      wb(n, 1'b1, 8);
      cyc(2);
      chk("chg ct", obs[8], !(n == 0 || n == 2));
      chk("load ct", obs[9], n != 1);
      rd(bpm_pkg::A_STATUS);
      chk("status", d[7:0], 8'h01 << n);
      if (n == 1) begin
        @(posedge clock_i) chg_rdy <= 1'b1;
        cyc(8);
        chk("load ct rdy", obs[9], 1'b1);
        chk("uv held", obs[1], 1'b1);
        @(posedge clock_i) chg_rdy <= 1'b0;
      end
      if (n == 0) begin
        @(posedge clock_i) cmax <= 16'h1054;
        cyc(10);
        chk("band", obs[0], 1'b1);
      end
      setm(n, 1'b0);
      wb(n, 1'b0, 8);
      cyc(2);
      chk("cts back", obs[9:8], 2'h3);
    end
    wr(bpm_pkg::A_CTRL, 32'h0001_00FF);
    setm(2, 1'b1);
    wb(2, 1'b1, 8);
    cyc(2);
    chk("switch", obs[10:8], 3'h3);
    setm(2, 1'b0);
    wb(10, 1'b1, 10);
    wr(bpm_pkg::A_CTRL, 32'h0000_00FF);
    $display("test channels done");
  endtask : t_each
  task t_delay;
    wr(8'h88, 32'h000F_FFFF);
    rd(8'h88);
    chk("dly clamp", d, 32'h0009_27C0);
    wr(8'h80, 32'h0000_FFFF);
    rd(8'h80);
    chk("thr clamp", d, 32'h0000_1194);
    wr(8'hA0, 32'h0000_FFFF);
    rd(8'hA0);
    chk("cur clamp", d, 32'h0000_02EE);
    wr(bpm_pkg::A_CTRL, 32'h0004_00FF);
    wr(8'hA0, 32'h0000_FFFF);
    rd(8'hA0);
    chk("big clamp", d, 32'h0000_1F40);
    wr(8'hA0, 32'h0000_01F4);
    wr(bpm_pkg::A_CTRL, 32'h0000_00FF);
    wr(8'hC0, 32'h0000_00FF);
    rd(8'hC0);
    chk("eot clamp", d, 32'h0000_009B);
    wr(8'hC0, 32'h0000_003C);
    wr(8'hD0, 32'h0000_8000);
    rd(8'hD0);
    chk("eut clamp", d, 32'h0000_FFD8);
    wr(8'hD0, 32'h0000_FFF6);
    wr(8'h80, 32'h0000_1068);
    wr(8'h88, 32'h0000_0004);
    wr(8'h8C, 32'h0000_0004);
    setm(0, 1'b1);
    cyc(30);
    setm(0, 1'b0);
    cyc(3);
    setm(0, 1'b1);
    cyc(20);
    chk("early", obs[0], 1'b0);
    wb(0, 1'b1, 40);
    setm(0, 1'b0);
    cyc(20);
    chk("held", obs[0], 1'b1);
    wb(0, 1'b0, 40);
    wr(8'h88, 32'h0000_0000);
    wr(8'h8C, 32'h0000_0000);
    $display("test delays done");
  endtask : t_delay
  task t_latch;
    wr(bpm_pkg::A_CTRL, 32'h0000_00FE);
    setm(0, 1'b1);
    cyc(10);
    chk("disabled", obs[0], 1'b0);
    setm(0, 1'b0);
    wr(bpm_pkg::A_CTRL, 32'h0000_01FF);
    setm(0, 1'b1);
    wb(0, 1'b1, 8);
    setm(0, 1'b0);
    cyc(10);
    chk("latched", obs[0], 1'b1);
    wr(bpm_pkg::A_CMD, 32'h0000_0001);
    cyc(3);
    chk("cleared", obs[0], 1'b0);
    setm(0, 1'b1);
    wb(0, 1'b1, 8);
    setm(0, 1'b0);
    @(posedge clock_i) prst <= 1'b1;
    cyc(3);
    @(posedge clock_i) prst <= 1'b0;
    wb(0, 1'b0, 10);
    wr(bpm_pkg::A_CTRL, 32'h0000_00FF);
    $display("test latch done");
  endtask : t_latch
  task t_pc;
    wr(bpm_pkg::A_PCDUR, 32'h0000_0001);
    wr(bpm_pkg::A_CTRL, 32'h0002_00FF);
    wr(bpm_pkg::A_CMD, 32'h0000_0002);
    wb(12, 1'b1, 5);
    cyc(40);
    @(posedge clock_i) stall <= 1'b1;
    cyc(30);
    chk("main early", obs[11], 1'b0);
    @(posedge clock_i) stall <= 1'b0;
    wb(11, 1'b1, 100);
    chk("near", load_v > 16'h0384, 1'b1);
    chk("pc off", obs[12], 1'b0);
    wr(bpm_pkg::A_CMD, 32'h0000_0004);
    @(posedge clock_i) stall <= 1'b1;
    wr(bpm_pkg::A_CMD, 32'h0000_0002);
    wb(12, 1'b1, 5);
    cyc(9900);
    chk("pc run", obs[12:11], 2'h2);
    wb(12, 1'b0, 200);
    chk("main off", obs[11], 1'b0);
    rd(bpm_pkg::A_STATUS);
    chk("pc state", d[12:11], 2'h3);
    wr(bpm_pkg::A_CTRL, 32'h0000_00FF);
    wr(bpm_pkg::A_CMD, 32'h0000_0002);
    wb(11, 1'b1, 5);
    chk("no pc", obs[12], 1'b0);
    $display("test pre-charge done");
  endtask : t_pc

  // ==========================================================
  // clock and main sequence
  initial begin
    forever #2 clock_i = ~clock_i;
  end
  initial begin
    repeat (12) @(posedge clock_i);
    reset_i <= 1'b0;
    cyc(2);
    chk("reset outs", obs, 32'h0000_0700);
    rd(bpm_pkg::A_CTRL);
    chk("ctrl", d, 32'h0000_00FF);
    rd(8'h20);
    chk("unmapped", d, 32'h0000_0000);
    $display("test reset done");
    t_each;
    t_delay;
    t_latch;
    t_pc;
    close_out;
  end
endmodule : bpm_top_tb
`default_nettype wire

// file: src/bpm_channel.sv
// one protection channel: delayed activation, delayed release, latch
`timescale 1ns/10ps
`default_nettype none
module bpm_channel (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic enable_i,
  input wire logic latch_i,
  input wire logic clear_i,
  input wire logic tick_i,
  input wire logic act_cond_i,
  input wire logic deact_cond_i,
  input wire logic [19:0] act_delay_i,
  input wire logic [19:0] deact_delay_i,
  output logic active_o
);

  typedef struct packed {
    logic active;
    logic [19:0] cnt;
  } bpm_chan_type;

  bpm_chan_type s;
  bpm_chan_type next_s;

  // ==========================================================
  // next state: one counter serves both delays
  always_comb begin
    next_s = s;
    if (reset_i || clear_i || !enable_i) begin
      next_s = '0;
    end else if (!s.active) begin
      if (!act_cond_i) begin
        next_s.cnt = '0;
      end else if (s.cnt >= act_delay_i) begin
        next_s.active = 1'b1;
        next_s.cnt = '0;
      end else if (tick_i) begin
        next_s.cnt = s.cnt + 20'h0_0001;
      end
    end else if (latch_i || !deact_cond_i) begin
      next_s.cnt = '0;
    end else if (s.cnt >= deact_delay_i) begin
      next_s.active = 1'b0;
      next_s.cnt = '0;
    end else if (tick_i) begin
      next_s.cnt = s.cnt + 20'h0_0001;
    end
  end

  always_ff @(posedge clock_i) begin
    s <= next_s;
  end

  assign active_o = s.active;

  // ==========================================================
  // checks
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);

  disabled_quiet_a: assert property (!enable_i |=> !active_o)
    else $error("disabled channel went active");
  act_delay_a: assert property ($rose(active_o) |->
    $past(act_cond_i) && ($past(s.cnt) >= $past(act_delay_i)))
    else $error("activated before its delay");
  deact_delay_a: assert property (
    $fell(active_o) && !$past(clear_i) && $past(enable_i) |->
    $past(deact_cond_i) && ($past(s.cnt) >= $past(deact_delay_i)))
    else $error("released before its delay");
  latch_hold_a: assert property (
    active_o && latch_i && enable_i && !clear_i |=> active_o)
    else $error("latched channel released");
  clear_drop_a: assert property (clear_i |=> !active_o)
    else $error("manual clear ignored");
  count_restart_a: assert property (
    !active_o && !act_cond_i |=> s.cnt == 20'h0_0000)
    else $error("delay count not restarted");
  latched_cleared_c: cover property (active_o && latch_i ##1 clear_i);

endmodule : bpm_channel
`default_nettype wire

// file: src/bpm_pkg.sv
// constants and types shared by the battery protection monitor
package bpm_pkg;

  // ==========================================================
  // protection channel numbering
  localparam int NPROT = 8;
  localparam logic [2:0] P_OV = 3'h0; // cell over-voltage
  localparam logic [2:0] P_UV = 3'h1; // cell under-voltage
  localparam logic [2:0] P_COC = 3'h2; // charge over-current
  localparam logic [2:0] P_DOC = 3'h3; // discharge over-current
  localparam logic [2:0] P_EOT = 3'h4; // external over-temperature
  localparam logic [2:0] P_EUT = 3'h5; // external under-temperature
  localparam logic [2:0] P_IOT = 3'h6; // internal over-temperature
  localparam logic [2:0] P_CCM = 3'h7; // cell count mismatch
  // channels that trip above the threshold, and signed channels
  localparam logic [7:0] OVER_MASK = 8'h5D;
  localparam logic [7:0] SIGNED_MASK = 8'h70;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CMD = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam logic [7:0] A_CELLS = 8'h0C;
  localparam logic [7:0] A_PCDUR = 8'h10;
  localparam logic [7:0] A_PROT = 8'h80; // +0x10 per channel
  // fields inside a channel block, from address bits 3:2
  localparam logic [1:0] F_ACT_THR = 2'h0;
  localparam logic [1:0] F_DEACT_THR = 2'h1;
  localparam logic [1:0] F_ACT_DLY = 2'h2;
  localparam logic [1:0] F_DEACT_DLY = 2'h3;
  // control and command bit positions
  localparam int C_LATCH = 8;
  localparam int C_CHGSW = 16;
  localparam int C_PCEN = 17;
  localparam int C_BIGCT = 18;
  localparam int K_CLEAR = 0;
  localparam int K_CLOSE = 1;
  localparam int K_OPEN = 2;

  // ==========================================================
  // threshold limits and values after reset, channel 7 first
  localparam logic [7:0][15:0] THR_LO = {16'h0000, 16'h0000, 16'hFFD8,
    16'h0014, 16'h0001, 16'h0001, 16'h03E8, 16'h03E8};
  localparam logic [7:0][15:0] THR_HI = {16'hFFFF, 16'h00C8, 16'h000A,
    16'h009B, 16'h1F40, 16'h1F40, 16'h1194, 16'h1194};
  localparam logic [15:0] CUR_HI_SMALL = 16'h02EE; // 75.0 A in 0.1 A
  localparam logic [7:0][15:0] ACT_RST = {16'h0000, 16'h0055, 16'hFFF6,
    16'h003C, 16'h01F4, 16'h01F4, 16'h0BB8, 16'h1068};
  localparam logic [7:0][15:0] DEACT_RST = {16'h0000, 16'h0050, 16'hFFFB,
    16'h0037, 16'h01C2, 16'h01C2, 16'h0C1C, 16'h1036};
  localparam logic [19:0] DLY_MAX = 20'h9_27C0; // 600 s in ms
  localparam logic [19:0] DLY_RST = 20'h0_03E8;
  localparam logic [7:0] CELLS_RST = 8'h10;
  localparam logic [4:0] PCDUR_LO = 5'h01;
  localparam logic [4:0] PCDUR_HI = 5'h1E;
  localparam logic [4:0] PCDUR_RST = 5'h0A;
  localparam logic [14:0] MS_PER_S = 15'h03E8;
  localparam logic [19:0] PCT_SCALE = 20'h0_000A; // ten percent band

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_PERIOD_NS = 1000000;
  localparam int MS_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;

  // pre-charge sequencer states
  typedef enum logic [1:0] {
    PC_OPEN, PC_RUN, PC_CLOSED, PC_FAIL
  } bpm_pc_type;

endpackage : bpm_pkg

// file: src/bpm_top.sv
// battery protection monitor: eight channels, contactors, pre-charge
//
// How it works
// - over-voltage trips, charger contactor opens
// - over-voltage clears, charger contactor recloses
// - under-voltage trips, load contactor opens
// - ready charger recloses load; clear needs voltage
// - charge over-current opens charger or switch
// - discharge over-current raised above threshold
// - external over-temperature raised above threshold
// - external under-temperature raised below threshold
// - internal over-temperature raised above threshold
// - cell count mismatch raised on difference
// - per-channel enable, all enabled after reset
// - separate activation and release thresholds
// - activation waits the activation delay
// - release waits the release delay
// - latch holds channel until manual reset
// - delays 0 to 600 s in ms
// - cell voltage thresholds 1.000 to 4.500 V
// - current threshold 0.1 to 75.0/800.0 A
// - external over-temperature 20 to 155 C
// - external under-temperature -40 to 10 C
// - pre-charge closes main within ten percent
// - pre-charge gives up after 1-30 s
// - protection reset input clears every channel
// - charger switch output drives a basic charger
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module bpm_top #(
  parameter int MS_CYCLES = bpm_pkg::MS_CYCLES
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [15:0] cell_max_mv_i,
  input wire logic [15:0] cell_min_mv_i,
  input wire logic [15:0] chg_current_i,
  input wire logic [15:0] dis_current_i,
  input wire logic [15:0] ext_temp_max_i,
  input wire logic [15:0] ext_temp_min_i,
  input wire logic [15:0] int_temp_i,
  input wire logic [7:0] cells_present_i,
  input wire logic [15:0] batt_volt_i,
  input wire logic [15:0] load_volt_i,
  input wire logic charger_ready_i,
  input wire logic prot_reset_i,
  output logic chg_contactor_o,
  output logic load_contactor_o,
  output logic charger_enable_o,
  output logic main_contactor_o,
  output logic precharge_o,
  output logic [7:0] prot_active_o
);

  typedef struct packed {
    logic [2:0] rdy_sync;
    logic [2:0] rst_sync;
    logic rdy_filt;
    logic rst_filt;
    logic [17:0] ms_cnt;
    logic tick;
    logic [7:0] enable;
    logic [7:0] latch;
    logic chgsw;
    logic pc_en;
    logic big_ct;
    logic clear;
    logic [7:0][15:0] act_thr;
    logic [7:0][15:0] deact_thr;
    logic [7:0][19:0] act_dly;
    logic [7:0][19:0] deact_dly;
    logic [7:0] cells_cfg;
    logic [4:0] pc_dur;
    bpm_pkg::bpm_pc_type pc_state;
    logic [14:0] pc_ms;
    logic chg_ct;
    logic load_ct;
    logic chg_en;
    logic main_ct;
    logic pc_out;
    logic [31:0] rdata;
  } bpm_state_type;

  bpm_state_type s;
  bpm_state_type next_s;
  logic [7:0] act_cond;
  logic [7:0] deact_cond;
  logic [7:0][15:0] meas;
  logic [15:0] pc_diff;
  logic pc_near;
  logic [14:0] pc_limit;

  // ==========================================================
  // helpers
  function automatic logic gt(input logic [15:0] a, input logic [15:0] b,
                              input logic sgn);
    gt = sgn ? ($signed(a) > $signed(b)) : (a > b);
  endfunction : gt

  function automatic logic [15:0] clamp(input logic [15:0] v,
    input logic [15:0] lo, input logic [15:0] hi, input logic sgn);
    if (gt(lo, v, sgn)) begin
      clamp = lo;
    end else if (gt(v, hi, sgn)) begin
      clamp = hi;
    end else begin
      clamp = v;
    end
  endfunction : clamp

  // ==========================================================
  // trip and release conditions per channel
  always_comb begin
    meas[bpm_pkg::P_OV] = cell_max_mv_i;
    meas[bpm_pkg::P_UV] = cell_min_mv_i;
    meas[bpm_pkg::P_COC] = chg_current_i;
    meas[bpm_pkg::P_DOC] = dis_current_i;
    meas[bpm_pkg::P_EOT] = ext_temp_max_i;
    meas[bpm_pkg::P_EUT] = ext_temp_min_i;
    meas[bpm_pkg::P_IOT] = int_temp_i;
    meas[bpm_pkg::P_CCM] = {8'h00, cells_present_i};
    for (int p = 0; p < bpm_pkg::NPROT; p++) begin
      if (bpm_pkg::OVER_MASK[p]) begin
        act_cond[p] = gt(meas[p], s.act_thr[p],
                         bpm_pkg::SIGNED_MASK[p]);
        deact_cond[p] = gt(s.deact_thr[p], meas[p],
                           bpm_pkg::SIGNED_MASK[p]);
      end else begin
        act_cond[p] = gt(s.act_thr[p], meas[p],
                         bpm_pkg::SIGNED_MASK[p]);
        deact_cond[p] = gt(meas[p], s.deact_thr[p],
                           bpm_pkg::SIGNED_MASK[p]);
      end
    end
    act_cond[bpm_pkg::P_CCM] = cells_present_i != s.cells_cfg;
    deact_cond[bpm_pkg::P_CCM] = cells_present_i == s.cells_cfg;
  end

  // pre-charge voltage comparison and time limit
  always_comb begin
    pc_diff = (batt_volt_i > load_volt_i) ? batt_volt_i - load_volt_i :
              load_volt_i - batt_volt_i;
    pc_near = (20'(pc_diff) * bpm_pkg::PCT_SCALE) <
              {4'h0, batt_volt_i};
    pc_limit = 15'(s.pc_dur * bpm_pkg::MS_PER_S);
  end

  // ==========================================================
  // protection channels
  for (genvar g = 0; g < bpm_pkg::NPROT; g++) begin : g_chan
    bpm_channel u_chan (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .enable_i(s.enable[g]),
      .latch_i(s.latch[g]),
      .clear_i(s.clear),
      .tick_i(s.tick),
      .act_cond_i(act_cond[g]),
      .deact_cond_i(deact_cond[g]),
      .act_delay_i(s.act_dly[g]),
      .deact_delay_i(s.deact_dly[g]),
      .active_o(prot_active_o[g])
    );
  end

  // ==========================================================
  // next state of the whole block
  always_comb begin
    logic [2:0] p;
    logic [15:0] hi;
    p = addr_i[6:4];
    hi = bpm_pkg::THR_HI[p];
    next_s = s;
    // pin inputs: three stages, accept when the last two agree
    next_s.rdy_sync = {s.rdy_sync[1:0], charger_ready_i};
    next_s.rst_sync = {s.rst_sync[1:0], prot_reset_i};
    if (s.rdy_sync[1] == s.rdy_sync[2]) begin
      next_s.rdy_filt = s.rdy_sync[2];
    end
    if (s.rst_sync[1] == s.rst_sync[2]) begin
      next_s.rst_filt = s.rst_sync[2];
    end
    // millisecond tick for all delays
    next_s.tick = 1'b0;
    if (s.ms_cnt >= 18'(MS_CYCLES - 1)) begin
      next_s.ms_cnt = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.ms_cnt = s.ms_cnt + 18'h0_0001;
    end
    // manual reset from the pin or from software
    next_s.clear = (next_s.rst_filt && !s.rst_filt) ||
                   (wr_i && addr_i == bpm_pkg::A_CMD &&
                    wdata_i[bpm_pkg::K_CLEAR]);
    // register writes, values held inside their legal ranges
    if (p == bpm_pkg::P_COC || p == bpm_pkg::P_DOC) begin
      if (!s.big_ct) begin
        hi = bpm_pkg::CUR_HI_SMALL;
      end
    end
    if (wr_i && addr_i[1:0] == 2'h0) begin
      if (addr_i[7]) begin
        case (addr_i[3:2])
          bpm_pkg::F_ACT_THR: next_s.act_thr[p] = clamp(wdata_i[15:0],
            bpm_pkg::THR_LO[p], hi,
            bpm_pkg::SIGNED_MASK[p]);
          bpm_pkg::F_DEACT_THR: next_s.deact_thr[p] = clamp(wdata_i[15:0],
            bpm_pkg::THR_LO[p], hi, bpm_pkg::SIGNED_MASK[p]);
          bpm_pkg::F_ACT_DLY: next_s.act_dly[p] =
            (wdata_i[19:0] > bpm_pkg::DLY_MAX) ? bpm_pkg::DLY_MAX :
            wdata_i[19:0];
          default: next_s.deact_dly[p] =
            (wdata_i[19:0] > bpm_pkg::DLY_MAX) ? bpm_pkg::DLY_MAX :
            wdata_i[19:0];
        endcase
      end else begin
        case (addr_i)
          bpm_pkg::A_CTRL: begin
            next_s.enable = wdata_i[7:0];
            next_s.latch = wdata_i[bpm_pkg::C_LATCH +: 8];
            next_s.chgsw = wdata_i[bpm_pkg::C_CHGSW];
            next_s.pc_en = wdata_i[bpm_pkg::C_PCEN];
            next_s.big_ct = wdata_i[bpm_pkg::C_BIGCT];
          end
          bpm_pkg::A_CELLS: next_s.cells_cfg = wdata_i[7:0];
          bpm_pkg::A_PCDUR: next_s.pc_dur = 5'(clamp({11'h000,
            wdata_i[4:0]}, {11'h000, bpm_pkg::PCDUR_LO},
            {11'h000, bpm_pkg::PCDUR_HI}, 1'b0));
          default: ;
        endcase
      end
    end
    // pre-charge sequencer
    case (s.pc_state)
      bpm_pkg::PC_RUN: begin
        if (s.tick) begin
          next_s.pc_ms = s.pc_ms + 15'h0001;
        end
        if (pc_near) begin
          next_s.pc_state = bpm_pkg::PC_CLOSED;
        end else if (s.pc_ms >= pc_limit) begin
          next_s.pc_state = bpm_pkg::PC_FAIL;
        end
      end
      bpm_pkg::PC_OPEN, bpm_pkg::PC_FAIL: begin
        if (wr_i && addr_i == bpm_pkg::A_CMD &&
            wdata_i[bpm_pkg::K_CLOSE]) begin
          next_s.pc_ms = '0;
          next_s.pc_state = s.pc_en ? bpm_pkg::PC_RUN :
                            bpm_pkg::PC_CLOSED;
        end
      end
      bpm_pkg::PC_CLOSED: ;
      default: next_s.pc_state = bpm_pkg::PC_OPEN;
    endcase
    if (wr_i && addr_i == bpm_pkg::A_CMD && wdata_i[bpm_pkg::K_OPEN]) begin
      next_s.pc_state = bpm_pkg::PC_OPEN;
    end
    // contactor and charger outputs
    next_s.chg_ct = !(prot_active_o[bpm_pkg::P_OV] ||
      (prot_active_o[bpm_pkg::P_COC] && !s.chgsw));
    next_s.chg_en = !(prot_active_o[bpm_pkg::P_COC] &&
                      s.chgsw);
    next_s.load_ct = !prot_active_o[bpm_pkg::P_UV] ||
                     s.rdy_filt;
    next_s.main_ct = next_s.pc_state == bpm_pkg::PC_CLOSED;
    next_s.pc_out = next_s.pc_state == bpm_pkg::PC_RUN;
    // read data stand for one cycle only
    next_s.rdata = '0;
    if (rd_i && addr_i[1:0] == 2'h0) begin
      if (addr_i[7]) begin
        case (addr_i[3:2])
          bpm_pkg::F_ACT_THR: next_s.rdata = {16'h0000, s.act_thr[p]};
          bpm_pkg::F_DEACT_THR: next_s.rdata = {16'h0000, s.deact_thr[p]};
          bpm_pkg::F_ACT_DLY: next_s.rdata = {12'h000, s.act_dly[p]};
          default: next_s.rdata = {12'h000, s.deact_dly[p]};
        endcase
      end else begin
        case (addr_i)
          bpm_pkg::A_CTRL: next_s.rdata = {13'h0000, s.big_ct, s.pc_en,
            s.chgsw, s.latch, s.enable};
          bpm_pkg::A_STATUS: next_s.rdata = {18'h0_0000, s.rdy_filt,
            s.pc_state, s.main_ct, s.load_ct, s.chg_ct,
            prot_active_o};
          bpm_pkg::A_CELLS: next_s.rdata = {24'h00_0000, s.cells_cfg};
          bpm_pkg::A_PCDUR: next_s.rdata = {27'h000_0000, s.pc_dur};
          default: next_s.rdata = '0;
        endcase
      end
    end
    // synchronous reset values
    if (reset_i) begin
      next_s = '0;
      next_s.enable = 8'hFF;
      next_s.act_thr = bpm_pkg::ACT_RST;
      next_s.deact_thr = bpm_pkg::DEACT_RST;
      next_s.act_dly = {bpm_pkg::NPROT{bpm_pkg::DLY_RST}};
      next_s.deact_dly = {bpm_pkg::NPROT{bpm_pkg::DLY_RST}};
      next_s.cells_cfg = bpm_pkg::CELLS_RST;
      next_s.pc_dur = bpm_pkg::PCDUR_RST;
      next_s.pc_state = bpm_pkg::PC_OPEN;
      next_s.chg_ct = 1'b1;
      next_s.load_ct = 1'b1;
      next_s.chg_en = 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    s <= next_s;
  end

  // ==========================================================
  // outputs straight from the state register
  assign rdata_o = s.rdata;
  assign chg_contactor_o = s.chg_ct;
  assign load_contactor_o = s.load_ct;
  assign charger_enable_o = s.chg_en;
  assign main_contactor_o = s.main_ct;
  assign precharge_o = s.pc_out;

  // ==========================================================
  // checks
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);

  ov_open_a: assert property (
    prot_active_o[0] |=> !chg_contactor_o)
    else $error("charger contactor closed during over-voltage");
  ov_recover_a: assert property (
    !prot_active_o[0] && !prot_active_o[2] |=> chg_contactor_o)
    else $error("charger contactor not reclosed");
  uv_open_a: assert property (
    prot_active_o[1] && !s.rdy_filt |=> !load_contactor_o)
    else $error("load contactor closed during under-voltage");
  uv_charger_a: assert property (
    s.rdy_filt |=> load_contactor_o)
    else $error("load contactor not reclosed for charger");
  coc_switch_a: assert property (
    prot_active_o[2] && s.chgsw |=> !charger_enable_o &&
      (chg_contactor_o != $past(prot_active_o[0])))
    else $error("charger switch not used for over-current");
  status_read_a: assert property (
    rd_i && addr_i == 8'h08 |=> rdata_o[7:0] == $past(prot_active_o))
    else $error("status read does not show channel flags");
  pc_close_a: assert property (
    s.pc_state == bpm_pkg::PC_RUN && pc_near && !wr_i
      |=> ##[0:1] main_contactor_o && !precharge_o)
    else $error("main contactor not closed when voltages agree");
  pc_fail_a: assert property (
    s.pc_state == bpm_pkg::PC_FAIL |-> !main_contactor_o && !precharge_o)
    else $error("contactor left driven after pre-charge timeout");
  thr_range_a: assert property (
    s.act_thr[0] >= 16'h03E8 && s.act_thr[0] <= 16'h1194)
    else $error("over-voltage threshold out of range");
  dly_range_a: assert property (
    s.act_dly[0] <= 20'h9_27C0 && s.deact_dly[0] <= 20'h9_27C0)
    else $error("delay setting out of range");

  ov_trip_c: cover property ($rose(prot_active_o[0]));
  pc_done_c: cover property (s.pc_state == bpm_pkg::PC_RUN
    ##1 s.pc_state == bpm_pkg::PC_CLOSED);
  pc_timeout_c: cover property ($rose(s.pc_state == bpm_pkg::PC_FAIL));
  pin_clear_c: cover property (s.clear && |prot_active_o);

endmodule : bpm_top
`default_nettype wire
